// [common/kms_pkg.sv]
package kms_pkg;
    // =========================================================
    // timing; divider and line length derived from the scan oscillator rate
    localparam int CLK_MHZ        = 100;
    localparam int OSC_MHZ        = 4;
    localparam int OSC_DIV        = CLK_MHZ / OSC_MHZ;
    localparam int LINE_TIME_US   = 200;
    localparam int LINE_OSC       = LINE_TIME_US * OSC_MHZ;
    localparam int SCAN_PERIOD_US = 25600;
    localparam int TEST_WIN_US    = 1600;
    localparam int DEBOUNCE_US    = 12800;
    localparam int FRAMES_PER_SCAN = SCAN_PERIOD_US / TEST_WIN_US;
    localparam int TEST1_FRAME    = 0;
    localparam int TEST2_FRAME    = DEBOUNCE_US / TEST_WIN_US;

    // =========================================================
    // geometry and widths
    localparam int NUM_LINES = 8;
    localparam int NUM_SENSE = 4;
    localparam int OSC_W     = 5;
    localparam int TICK_W    = 10;
    localparam int LINE_W    = 3;
    localparam int FRAME_W   = 4;
    localparam int DUTY_STEPS = 16;
    localparam int TEST_DUTY  = 7;

    localparam logic [NUM_SENSE-1:0] SENSE_IDLE  = 4'hf;
    localparam logic [7:0]           SEG_ALL_ON  = 8'hff;
    localparam logic [7:0]           SEG_ALL_OFF = 8'h00;

    // =========================================================
    // types
    typedef logic [NUM_SENSE-1:0][NUM_LINES-1:0] kms_bank_type;

    typedef struct packed {
        logic       valid;     // one-cycle read strobe
        logic       debounced; // 1: debounced bank, 0: pressed bank
        logic [1:0] idx;       // sense line a..d
    } kms_rd_type;

    typedef struct packed {
        logic       valid;     // one-cycle mask write strobe
        logic [1:0] idx;
        logic [7:0] data;
    } kms_wr_type;
endpackage

// [rtl/kms_sense_sync.sv]
module kms_sense_sync
    import kms_pkg::*;
(
    input  wire logic                 clk_sys_in,   // system clock
    input  wire logic                 resetn_in,    // async reset, low
    input  wire logic [NUM_SENSE-1:0] pins_in,      // raw sense pins
    output logic      [NUM_SENSE-1:0] level_out     // settled levels
);
    typedef struct packed {
        logic [NUM_SENSE-1:0] s1;
        logic [NUM_SENSE-1:0] s2;
        logic [NUM_SENSE-1:0] s3;
        logic [NUM_SENSE-1:0] lvl;
    } kms_sync_type;

    kms_sync_type st_r;
    kms_sync_type st_nxt;

    // s1 feeds only s2; a bit moves once s2 and s3 agree
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = pins_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < NUM_SENSE; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.lvl[i] = st_r.s3[i];
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_r <= '{SENSE_IDLE, SENSE_IDLE, SENSE_IDLE, SENSE_IDLE};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level_out = st_r.lvl;
endmodule

// [rtl/kms_scan_top.sv]
// How it works
// - every key is tested twice in each 25.6 ms scan period
// - first 1.6 ms test samples sense lines per low scan line
// - second 1.6 ms test sets debounced bit if key still closed
// - the two tests of a key are 12.8 ms apart
// - four write-only mask banks gate debounce events onto the irq
// - with scanning enabled, pressed status updates whatever the masks
// - debounced bit stays set until its bank is read
// - reading a debounced bank returns it, then clears it
// - unread debounced banks accumulate further events, no order kept
// - reading any debounced bank releases the interrupt pin
// - a held key reports once; it must be seen released first
// - pressed bit mirrors the key state at the latest test
// - reading a pressed bank changes nothing
// - display test lights all segments, overriding controls and shutdown
// - display test runs segments at 7/16 duty
// - the eight scan lines go low in turn, 200 us each
// - with scanning enabled the fifth port pin carries the interrupt
module kms_scan_top
    import kms_pkg::*;
#(
    parameter int OSC_DIV_CYC  = OSC_DIV,
    parameter int LINE_OSC_CYC = LINE_OSC
) (
    input  wire logic                 clk_sys_in,     // 100 MHz clock
    input  wire logic                 resetn_in,      // async reset, low
    input  wire logic                 scan_en_in,     // key scan enable
    input  wire logic [NUM_SENSE-1:0] sense_port_pins_in, // pins, low=closed
    input  wire kms_pkg::kms_rd_type  rd_in,          // status read strobe
    input  wire kms_pkg::kms_wr_type  mask_wr_in,     // mask bank write
    input  wire logic                 display_test_in, // display test mode
    input  wire logic                 shutdown_in,    // display shutdown
    input  wire logic [3:0]           intensity_in,   // normal duty, /16
    input  wire logic [7:0]           seg_data_in,    // bit7 = decimal_point
    input  wire logic                 gpio_pin5_in,   // gpio value for pin 5
    input  wire logic                 gpio_pin5_oe_n_in, // gpio enable, low
    output logic      [7:0]           rd_data_out,    // read data
    output logic [NUM_LINES-1:0]      scan_line_outputs_out, // low = active
    output logic      [7:0]           seg_out,        // bit7 = decimal_point
    output logic                      irq_pending_out, // interrupt level
    output logic                      interrupt_port_pin_out, // pin 5 value
    output logic                      interrupt_port_pin_oe_n_out // low=drive
);
    import kms_pkg::*;

    localparam int SLOT_CYC = (LINE_OSC_CYC >= DUTY_STEPS) ?
                              LINE_OSC_CYC / DUTY_STEPS : 1;

    // =========================================================
    // state
    typedef struct packed {
        logic [OSC_W-1:0]   osc_cnt;
        logic [TICK_W-1:0]  tick_cnt;
        logic [LINE_W-1:0]  line;
        logic [FRAME_W-1:0] frame;
        kms_bank_type       pressed;
        kms_bank_type       debounced;
        kms_bank_type       reported;
        kms_bank_type       mask;
        logic               irq;
        logic [7:0]         rd_data;
        logic [7:0]         seg;
    } kms_state_type;

    kms_state_type        st_r;
    kms_state_type        st_nxt;
    logic [NUM_SENSE-1:0] sense_lvl;
    logic                 osc_en;
    logic                 line_end;
    logic                 test1;
    logic                 test2;
    int                   slot;

    kms_sense_sync u_sync (
        .clk_sys_in (clk_sys_in),
        .resetn_in  (resetn_in),
        .pins_in    (sense_port_pins_in),
        .level_out  (sense_lvl)
    );

    // =========================================================
    // oscillator-rate timebase
    assign osc_en   = st_r.osc_cnt == OSC_W'(OSC_DIV_CYC - 1);
    assign line_end = osc_en &&
                      (st_r.tick_cnt == TICK_W'(LINE_OSC_CYC - 1));
    assign test1    = line_end && scan_en_in &&
                      (st_r.frame == FRAME_W'(TEST1_FRAME));
    assign test2    = line_end && scan_en_in &&
                      (st_r.frame == FRAME_W'(TEST2_FRAME));
    assign slot     = int'(st_r.tick_cnt) / SLOT_CYC;

    always_comb begin
        st_nxt = st_r;
        if (osc_en) begin
            st_nxt.osc_cnt  = '0;
            st_nxt.tick_cnt = st_r.tick_cnt + TICK_W'(1);
        end else begin
            st_nxt.osc_cnt  = st_r.osc_cnt + OSC_W'(1);
        end
        if (line_end) begin
            st_nxt.tick_cnt = '0;
            st_nxt.line     = st_r.line + LINE_W'(1);
            if (st_r.line == LINE_W'(NUM_LINES - 1)) begin
                if (st_r.frame == FRAME_W'(FRAMES_PER_SCAN - 1)) begin
                    st_nxt.frame = '0;
                end else begin
                    st_nxt.frame = st_r.frame + FRAME_W'(1);
                end
            end
        end

        // register-side accesses; clears first so key events win below
        if (mask_wr_in.valid) begin
            st_nxt.mask[mask_wr_in.idx] = mask_wr_in.data;
        end
        if (rd_in.valid) begin
            if (rd_in.debounced) begin
                st_nxt.rd_data = st_r.debounced[rd_in.idx];
                st_nxt.debounced[rd_in.idx] = '0;
                st_nxt.irq = 1'b0;
            end else begin
                st_nxt.rd_data = st_r.pressed[rd_in.idx];
            end
        end

        // key tests on the line that is low now
        for (int s = 0; s < NUM_SENSE; s++) begin
            if (test1 || test2) begin
                st_nxt.pressed[s][st_r.line] = !sense_lvl[s];
                if (sense_lvl[s]) begin
                    st_nxt.reported[s][st_r.line] = 1'b0;
                end
            end
            // a key closed at both tests and not yet reported
            if (test2 && !sense_lvl[s] && st_r.pressed[s][st_r.line] &&
                !st_r.reported[s][st_r.line]) begin
                st_nxt.debounced[s][st_r.line] = 1'b1;
                st_nxt.reported[s][st_r.line]  = 1'b1;
                if (st_r.mask[s][st_r.line]) begin
                    st_nxt.irq = 1'b1;
                end
            end
        end

        // segment drive; test mode ignores data, intensity and shutdown
        if (display_test_in) begin
            st_nxt.seg = (slot < TEST_DUTY) ? SEG_ALL_ON : SEG_ALL_OFF;
        end else if (shutdown_in || slot >= int'(intensity_in)) begin
            st_nxt.seg = SEG_ALL_OFF;
        end else begin
            st_nxt.seg = seg_data_in;
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // =========================================================
    // outputs
    assign rd_data_out           = st_r.rd_data;
    assign seg_out               = st_r.seg;
    assign irq_pending_out       = st_r.irq;
    // cathodes also serve the display, so they run even with scan off
    assign scan_line_outputs_out = ~(NUM_LINES'(1) << st_r.line);
    // open drain with scanning enabled: pin held low while an interrupt is pending; gpio otherwise
    assign interrupt_port_pin_out      = scan_en_in ? 1'b0 : gpio_pin5_in;
    assign interrupt_port_pin_oe_n_out = scan_en_in ? !st_r.irq :
                                         gpio_pin5_oe_n_in;

    // =========================================================
    // checks
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);

    sequence db_read_s;
        rd_in.valid && rd_in.debounced && !test2;
    endsequence

    AST_ONE_LINE_LOW: assert property (
        $onehot(~scan_line_outputs_out))
        else $error("scan lines not one-hot low");

    AST_LINE_STEP: assert property (
        $changed(st_r.line) |-> $past(line_end))
        else $error("scan line moved off its 200 us boundary");

    AST_TEST1_SAMPLE: assert property (
        test1 |=> st_r.pressed[0][$past(st_r.line)] == !$past(sense_lvl[0]))
        else $error("first test did not capture key a");

    AST_DB_ONLY_TEST2: assert property (
        (st_r.debounced & ~$past(st_r.debounced)) != '0 |->
        $past(test2) && $past(st_r.frame) == FRAME_W'(TEST2_FRAME))
        else $error("debounced bit set outside second test");

    AST_DB_READ_CLEARS: assert property (
        db_read_s |=> st_r.debounced[$past(rd_in.idx)] == '0 &&
        rd_data_out == $past(st_r.debounced[rd_in.idx]))
        else $error("debounced read did not return then clear");

    AST_IRQ_RELEASE: assert property (
        db_read_s |=> !irq_pending_out ##0 (!interrupt_port_pin_oe_n_out
        == 1'b0 || !scan_en_in))
        else $error("debounced read left interrupt asserted");

    AST_PRESSED_READ_PURE: assert property (
        rd_in.valid && !rd_in.debounced && !line_end |=>
        $stable(st_r.pressed) && $stable(st_r.debounced) &&
        $stable(irq_pending_out))
        else $error("pressed read had a side effect");

    AST_IRQ_MASKED: assert property (
        $rose(irq_pending_out) |->
        $past(test2) && ((st_r.debounced & $past(st_r.mask)) != '0))
        else $error("interrupt rose without a masked event");

    AST_TEST_DUTY: assert property (
        display_test_in && slot >= TEST_DUTY ##1 display_test_in |->
        seg_out == SEG_ALL_OFF)
        else $error("display test duty exceeds 7/16");

    AST_HELD_ONCE: assert property (
        test2 && st_r.reported[0][st_r.line] && !sense_lvl[0] |=>
        st_r.debounced[0][$past(st_r.line)] ==
        $past(st_r.debounced[0][st_r.line]) || $past(rd_in.valid))
        else $error("held key debounced twice");
endmodule

// [test/kms_key_matrix.sv]
// =========================================================
// key switch matrix with one diode a key and pull-ups on
// the sense pins; a closed key pulls its sense pin low only
// while its own scan line is driven low
module kms_key_matrix
    import kms_pkg::*;
(
    input  wire logic [NUM_LINES-1:0] scan_lines_in, // low = line active
    input  wire kms_pkg::kms_bank_type keys_in,      // 1 = key closed
    output logic      [NUM_SENSE-1:0] sense_out      // pulled up when idle
);
    timeunit 1ns;
    timeprecision 1ps;

    always_comb begin
        for (int s = 0; s < NUM_SENSE; s++) begin
            sense_out[s] = ~|(keys_in[s] & ~scan_lines_in);
        end
    end
endmodule

// [test/key_matrix_scan_debounce_tb_top.sv]
module key_matrix_scan_debounce_tb_top
    import kms_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // short counts: one scan line lasts 64 clocks
    localparam int LINE_CYC = 2 * 32;
    localparam int WAIT_CYC = 2 * 16 * 8 * LINE_CYC + 600;
    // the tests take about four and a half long waits
    localparam int LIMIT_CYC = 5 * WAIT_CYC + 4000;

    logic                 clk_sys_in;
    logic                 resetn_in;
    logic                 scan_en_in;
    logic [NUM_SENSE-1:0] sense;
    kms_rd_type           rd_in;
    kms_wr_type           mask_wr_in;
    logic                 display_test_in;
    logic                 shutdown_in;
    logic [3:0]           intensity_in;
    logic [7:0]           seg_data_in;
    logic                 gpio_pin5_in;
    logic                 gpio_pin5_oe_n_in;
    logic [7:0]           rd_data_out;
    logic [7:0]           scan_lines;
    logic [7:0]           seg_out;
    logic                 irq;
    logic                 pin;
    logic                 pin_oe_n;
    kms_bank_type         keys;
    int                   err_total;
    int                   check_count;

    kms_scan_top #(.OSC_DIV_CYC(2), .LINE_OSC_CYC(32)) dut (
        .clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
        .scan_en_in(scan_en_in), .sense_port_pins_in(sense),
        .rd_in(rd_in), .mask_wr_in(mask_wr_in),
        .display_test_in(display_test_in), .shutdown_in(shutdown_in),
        .intensity_in(intensity_in), .seg_data_in(seg_data_in),
        .gpio_pin5_in(gpio_pin5_in),
        .gpio_pin5_oe_n_in(gpio_pin5_oe_n_in),
        .rd_data_out(rd_data_out), .scan_line_outputs_out(scan_lines),
        .seg_out(seg_out), .irq_pending_out(irq),
        .interrupt_port_pin_out(pin),
        .interrupt_port_pin_oe_n_out(pin_oe_n));

    kms_key_matrix matrix (
        .scan_lines_in(scan_lines), .keys_in(keys), .sense_out(sense));

    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    // =========================================================
    // access tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic rd(input logic deb, input logic [1:0] idx,
                      output logic [7:0] data);
        @(posedge clk_sys_in);
        rd_in <= '{valid: 1'b1, debounced: deb, idx: idx};
        @(posedge clk_sys_in);
        rd_in <= '0;
        #1;
        data = rd_data_out;
    endtask

    task automatic wr_mask(input logic [1:0] idx, input logic [7:0] d);
        @(posedge clk_sys_in);
        mask_wr_in <= '{valid: 1'b1, idx: idx, data: d};
        @(posedge clk_sys_in);
        mask_wr_in <= '0;
    endtask

    // bounded wait; n = clocks until the active scan line moves
    task automatic line_step(output int n);
        logic [7:0] cur;
        cur = scan_lines;
        n = 0;
        while (scan_lines === cur && n < 2 * LINE_CYC) begin
            @(posedge clk_sys_in);
            #1;
            n++;
        end
    endtask

    task automatic count_on(output int c);
        c = 0;
        repeat (LINE_CYC) begin
            @(posedge clk_sys_in);
            #1;
            if (seg_out === SEG_ALL_ON) c++;
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (LIMIT_CYC) @(posedge clk_sys_in);
        err_total++;
        end_of_test();
    end

    // =========================================================
    // tests
    initial begin
        logic [7:0] v;
        logic [7:0] prev;
        int         n;
        resetn_in = 1'b0;
        scan_en_in = 1'b1;
        keys = '0;
        rd_in = '0;
        mask_wr_in = '0;
        display_test_in = 1'b0;
        shutdown_in = 1'b1;
        intensity_in = 4'hf;
        seg_data_in = 8'h00;
        gpio_pin5_in = 1'b1;
        gpio_pin5_oe_n_in = 1'b0;
        err_total = 0;
        check_count = 0;
        repeat (5) @(posedge clk_sys_in);
        #1;
        check(scan_lines, 8'hfe);
        check({7'h00, irq}, 8'h00);
        @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        line_step(n);
        for (int i = 0; i < NUM_LINES; i++) begin
            prev = scan_lines;
            line_step(n);
            check(scan_lines, {prev[6:0], prev[7]});
            check(8'(n), 8'(LINE_CYC));
        end
        // shutdown stays set: test mode must override it
        @(posedge clk_sys_in);
        display_test_in <= 1'b1;
        count_on(n);
        count_on(n);
        check(8'(n), 8'(TEST_DUTY * LINE_CYC / DUTY_STEPS));
        @(posedge clk_sys_in);
        display_test_in <= 1'b0;
        count_on(n);
        count_on(n);
        check(8'(n), 8'h00);
        wr_mask(2'd1, 8'h08);
        keys[1][3] <= 1'b1;
        repeat (WAIT_CYC) @(posedge clk_sys_in);
        #1;
        check({7'h00, irq}, 8'h01);
        check({6'h00, pin, pin_oe_n}, 8'h00);
        rd(1'b0, 2'd1, v);
        check(v, 8'h08);
        check({7'h00, irq}, 8'h01);
        rd(1'b1, 2'd1, v);
        check(v, 8'h08);
        check({7'h00, irq}, 8'h00);
        check({6'h00, pin, pin_oe_n}, 8'h01);
        rd(1'b1, 2'd1, v);
        check(v, 8'h00);
        repeat (WAIT_CYC) @(posedge clk_sys_in);
        rd(1'b1, 2'd1, v);
        check(v, 8'h00);
        check({7'h00, irq}, 8'h00);
        keys[1][3] <= 1'b0;
        keys[0][7] <= 1'b1;
        repeat (WAIT_CYC) @(posedge clk_sys_in);
        rd(1'b0, 2'd1, v);
        check(v, 8'h00);
        keys[0][7] <= 1'b0;
        keys[0][2] <= 1'b1;
        repeat (WAIT_CYC) @(posedge clk_sys_in);
        #1;
        check({7'h00, irq}, 8'h00);
        // host sweeps all four debounced banks
        for (int i = 0; i < NUM_SENSE; i++) begin
            rd(1'b1, 2'(i), v);
            check(v, (i == 0) ? 8'h84 : 8'h00);
        end
        @(posedge clk_sys_in);
        scan_en_in <= 1'b0;
        keys[3][5] <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
        #1;
        check({6'h00, pin, pin_oe_n}, 8'h02);
        repeat (WAIT_CYC / 2) @(posedge clk_sys_in);
        rd(1'b0, 2'd3, v);
        check(v, 8'h00);
        rd(1'b0, 2'd0, v);
        check(v, 8'h04);
        end_of_test();
    end
endmodule
